// File: rtl/tmw_timer.sv
/*
 * Timer waveform block: 16-bit counter with normal, clear-on-match and
 * fast pulse-width modes, two compare channels, prescaler and AHB-Lite
 * register slave.
 * Assumes a single 50 MHz clock and a synchronous active-high reset.
 */
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module tmw_timer
    import tmw_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [1:0] PORT_OUT,
    output logic [1:0] PIN_OUT,
    output logic [1:0] PIN_OE
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    tmw_ahb_req_t req;
    logic [31:0] addr_q;
    logic wr_q;
    logic [31:0] rdata_q;
    logic [3:0] mode_q;
    logic [1:0] com_a_q;
    logic [1:0] com_b_q;
    logic [2:0] pre_q;
    logic dir_a_q;
    logic dir_b_q;
    logic [15:0] count_q;
    logic [15:0] cmpa_q;
    logic [15:0] cmpa_buf_q;
    logic [15:0] cmpb_q;
    logic [15:0] cmpb_buf_q;
    logic [15:0] capt_q;
    logic ovf_q;
    logic fa_q;
    logic fb_q;
    logic fc_q;
    logic block_q;
    tmw_oc_t oc_q;
    logic [9:0] pre_cnt_q;
    logic tick;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmpa;
    logic wr_cmpb;
    logic wr_capt;
    logic wr_flags;
    logic wr_force;
    logic fast;
    logic clear_on_match_mode;
    logic [15:0] top;
    logic at_top;
    logic at_max;
    logic match_a;
    logic match_b;
    logic [15:0] wmask;

    // Write data is applied in the data phase; matches act on ticks.
    function automatic logic apply_com(input logic [1:0] com,
                                       input logic cur);
        unique case (tmw_com_t'(com))
            TMW_COM_OFF: apply_com = cur;
            TMW_COM_TOGGLE: apply_com = ~cur;
            TMW_COM_CLEAR: apply_com = 1'b0;
            TMW_COM_SET: apply_com = 1'b1;
        endcase
    endfunction : apply_com

    // Fast-mode action on a compare match, inverted at top.
    function automatic logic fast_match(input logic [1:0] com,
                                        input logic cur);
        unique case (tmw_com_t'(com))
            TMW_COM_OFF: fast_match = cur;
            TMW_COM_TOGGLE: fast_match = cur;
            TMW_COM_CLEAR: fast_match = 1'b1;
            TMW_COM_SET: fast_match = 1'b0;
        endcase
    endfunction : fast_match

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Collect the address phase signals into one carrier.
    assign req = '{haddr: HADDR, htrans: HTRANS, hwrite: HWRITE,
                   hsize: HSIZE, hsel: HSEL, hready: HREADY};
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_q;

    // Capture the address phase of each write.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wr_q <= 1'b0;
            addr_q <= 32'h0000_0000;
        end else if (req.hready) begin
            wr_q <= req.hsel && req.htrans == TMW_HTRANS_NONSEQ &&
                    req.hwrite;
            addr_q <= req.haddr;
        end
    end

    // Decode the pending write in its data phase.
    always_comb begin
        wr_ctrl = wr_q && addr_q[7:0] == TMW_OFS_CTRL;
        wr_count = wr_q && addr_q[7:0] == TMW_OFS_COUNT;
        wr_cmpa = wr_q && addr_q[7:0] == TMW_OFS_CMPA;
        wr_cmpb = wr_q && addr_q[7:0] == TMW_OFS_CMPB;
        wr_capt = wr_q && addr_q[7:0] == TMW_OFS_CAPT;
        wr_flags = wr_q && addr_q[7:0] == TMW_OFS_FLAGS;
        wr_force = wr_q && addr_q[7:0] == TMW_OFS_FORCE;
    end

    // Read data is registered at the address phase; unmapped reads zero.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_q <= TMW_RDATA_ZERO;
        end else if (req.hready && req.hsel && !req.hwrite &&
                     req.htrans == TMW_HTRANS_NONSEQ) begin
            unique case (req.haddr[7:0])
                TMW_OFS_CTRL: rdata_q <= {19'h0, dir_b_q, dir_a_q, pre_q,
                                          com_b_q, com_a_q, mode_q};
                TMW_OFS_COUNT: rdata_q <= {16'h0, count_q};
                TMW_OFS_CMPA: rdata_q <= {16'h0, fast ? cmpa_buf_q : cmpa_q};
                TMW_OFS_CMPB: rdata_q <= {16'h0, fast ? cmpb_buf_q : cmpb_q};
                TMW_OFS_CAPT: rdata_q <= {16'h0, capt_q};
                TMW_OFS_FLAGS: rdata_q <= {28'h0, fc_q, fb_q, fa_q, ovf_q};
                TMW_OFS_STATE: rdata_q <= {30'h0, oc_q.b, oc_q.a};
                default: rdata_q <= TMW_RDATA_ZERO;
            endcase
        end
    end

    // Control register: mode, output actions, prescaler, directions.
    // The compare state consults the output mode only at a match, a top or a force write; the pin mux uses it at once.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mode_q <= TMW_MODE_NORMAL;
            com_a_q <= 2'h0;
            com_b_q <= 2'h0;
            pre_q <= TMW_PRE_STOP;
            dir_a_q <= 1'b0;
            dir_b_q <= 1'b0;
        end else if (wr_ctrl) begin
            mode_q <= HWDATA[TMW_CTRL_MODE_LSB +: 4];
            com_a_q <= HWDATA[TMW_CTRL_COMA_LSB +: 2];
            com_b_q <= HWDATA[TMW_CTRL_COMB_LSB +: 2];
            pre_q <= HWDATA[TMW_CTRL_PRE_LSB +: 3];
            dir_a_q <= HWDATA[TMW_CTRL_DIRA];
            dir_b_q <= HWDATA[TMW_CTRL_DIRB];
        end
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // Free-running divider; the tick is a one-cycle enable.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pre_cnt_q <= 10'h000;
        end else begin
            pre_cnt_q <= pre_cnt_q + 10'h001;
        end
    end

    always_comb begin
        unique case (pre_q)
            TMW_PRE_1: tick = 1'b1;
            TMW_PRE_8: tick = (pre_cnt_q & TMW_DIV_8) == TMW_DIV_8;
            TMW_PRE_64: tick = (pre_cnt_q & TMW_DIV_64) == TMW_DIV_64;
            TMW_PRE_256: tick = (pre_cnt_q & TMW_DIV_256) == TMW_DIV_256;
            TMW_PRE_1024: tick = pre_cnt_q == TMW_DIV_1024;
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Mode decode and compare
    // ------------------------------------------------------------------
    // Select top and resolution mask from the mode.
    always_comb begin
        fast = 1'b0;
        clear_on_match_mode = 1'b0;
        top = TMW_MAX;
        wmask = TMW_MAX;
        unique case (mode_q)
            TMW_MODE_CTC_A: begin clear_on_match_mode = 1'b1; top = cmpa_q; end
            TMW_MODE_CTC_C: begin clear_on_match_mode = 1'b1; top = capt_q; end
            TMW_MODE_FAST8: begin
                fast = 1'b1; top = TMW_TOP_8BIT; wmask = TMW_TOP_8BIT;
            end
            TMW_MODE_FAST9: begin
                fast = 1'b1; top = TMW_TOP_9BIT; wmask = TMW_TOP_9BIT;
            end
            TMW_MODE_FAST10: begin
                fast = 1'b1; top = TMW_TOP_10BIT; wmask = TMW_TOP_10BIT;
            end
            TMW_MODE_FAST_C: begin fast = 1'b1; top = capt_q; end
            TMW_MODE_FAST_A: begin fast = 1'b1; top = cmpa_q; end
            default: ;
        endcase
    end

    // Equality only, so a top below the count is missed.
    assign at_top = (clear_on_match_mode || fast) && count_q == top;
    assign at_max = count_q == TMW_MAX;
    assign match_a = !block_q && count_q == cmpa_q;
    assign match_b = !block_q && count_q == cmpb_q;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Count up on ticks; clear at top in clear-on-match and fast modes.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            count_q <= TMW_RST_VALUE;
        end else if (wr_count) begin
            count_q <= HWDATA[15:0];
        end else if (tick) begin
            if (at_top && !block_q) begin
                count_q <= TMW_RST_VALUE;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // A counter write blocks matches for the next timer cycle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Compare and capture registers
    // ------------------------------------------------------------------
    // Direct in non-PWM modes, via buffer in fast modes.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cmpa_q <= TMW_RST_VALUE;
            cmpa_buf_q <= TMW_RST_VALUE;
            cmpb_q <= TMW_RST_VALUE;
            cmpb_buf_q <= TMW_RST_VALUE;
        end else begin
            if (wr_cmpa) begin
                cmpa_buf_q <= HWDATA[15:0] & wmask;
            end
            if (wr_cmpb) begin
                cmpb_buf_q <= HWDATA[15:0] & wmask;
            end
            if (wr_cmpa && !fast) begin
                cmpa_q <= HWDATA[15:0] & wmask;
            end else if (fast && tick && at_top && !block_q) begin
                cmpa_q <= cmpa_buf_q;
            end
            if (wr_cmpb && !fast) begin
                cmpb_q <= HWDATA[15:0] & wmask;
            end else if (fast && tick && at_top && !block_q) begin
                cmpb_q <= cmpb_buf_q;
            end
        end
    end

    // Capture register is always unbuffered.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            capt_q <= TMW_RST_VALUE;
        end else if (wr_capt) begin
            capt_q <= HWDATA[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // Flags clear by writing one; a hardware set wins over the clear.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ovf_q <= 1'b0;
            fa_q <= 1'b0;
            fb_q <= 1'b0;
            fc_q <= 1'b0;
        end else begin
            if (tick && (fast ? at_top && !block_q : at_max)) begin
                ovf_q <= 1'b1;
            end else if (wr_flags && HWDATA[TMW_FLG_OVF]) begin
                ovf_q <= 1'b0;
            end
            if (tick && (match_a ||
                (at_top && !block_q && (mode_q == TMW_MODE_CTC_A ||
                                        mode_q == TMW_MODE_FAST_A)))) begin
                fa_q <= 1'b1;
            end else if (wr_flags && HWDATA[TMW_FLG_CMPA]) begin
                fa_q <= 1'b0;
            end
            if (tick && match_b) begin
                fb_q <= 1'b1;
            end else if (wr_flags && HWDATA[TMW_FLG_CMPB]) begin
                fb_q <= 1'b0;
            end
            if (tick && at_top && !block_q && (mode_q == TMW_MODE_CTC_C ||
                                               mode_q == TMW_MODE_FAST_C)) begin
                fc_q <= 1'b1;
            end else if (wr_flags && HWDATA[TMW_FLG_CAPT]) begin
                fc_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare output state
    // ------------------------------------------------------------------
    // Match sets, clears or toggles; in fast modes top applies the opposite level.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            oc_q <= '0;
        end else if (!fast && wr_force) begin
            // Force touches only the outputs.
            if (HWDATA[TMW_FRC_A]) begin
                oc_q.a <= apply_com(com_a_q, oc_q.a);
            end
            if (HWDATA[TMW_FRC_B]) begin
                oc_q.b <= apply_com(com_b_q, oc_q.b);
            end
        end else if (tick) begin
            if (!fast) begin
                if (match_a) oc_q.a <= apply_com(com_a_q, oc_q.a);
                if (match_b) oc_q.b <= apply_com(com_b_q, oc_q.b);
            end else begin
                if (match_a && com_a_q == TMW_COM_TOGGLE &&
                    mode_q == TMW_MODE_FAST_A) begin
                    oc_q.a <= ~oc_q.a;
                end else if (at_top && !block_q &&
                             com_a_q[1] && count_q != cmpa_q) begin
                    oc_q.a <= com_a_q[0];
                end else if (match_a) begin
                    oc_q.a <= fast_match(com_a_q, oc_q.a);
                end
                if (at_top && !block_q && com_b_q[1] &&
                    count_q != cmpb_q) begin
                    oc_q.b <= com_b_q[0];
                end else if (match_b) begin
                    oc_q.b <= fast_match(com_b_q, oc_q.b);
                end
            end
        end
    end

    // Pins follow the compare state when the output action is not off; directions drive only the enables.
    always_comb begin
        PIN_OE = {dir_b_q, dir_a_q};
        PIN_OUT[0] = (com_a_q != 2'h0) ? oc_q.a : PORT_OUT[0];
        PIN_OUT[1] = (com_b_q != 2'h0) ? oc_q.b : PORT_OUT[1];
    end

endmodule : tmw_timer

// File: rtl/tmw_pkg.sv
/*
 * Package for the 16-bit timer waveform block: register map, field
 * positions, reset values, mode codes and bus structs.
 * Assumes an AHB-Lite slave with 32-bit data and word registers.
 */
package tmw_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TMW_OFS_CTRL = 8'h00;
    localparam logic [7:0] TMW_OFS_COUNT = 8'h04;
    localparam logic [7:0] TMW_OFS_CMPA = 8'h08;
    localparam logic [7:0] TMW_OFS_CMPB = 8'h0C;
    localparam logic [7:0] TMW_OFS_CAPT = 8'h10;
    localparam logic [7:0] TMW_OFS_FLAGS = 8'h14;
    localparam logic [7:0] TMW_OFS_FORCE = 8'h18;
    localparam logic [7:0] TMW_OFS_STATE = 8'h1C;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int TMW_CTRL_MODE_LSB = 0;
    localparam int TMW_CTRL_COMA_LSB = 4;
    localparam int TMW_CTRL_COMB_LSB = 6;
    localparam int TMW_CTRL_PRE_LSB = 8;
    localparam int TMW_CTRL_DIRA = 11;
    localparam int TMW_CTRL_DIRB = 12;

    // Flag bit positions.
    localparam int TMW_FLG_OVF = 0;
    localparam int TMW_FLG_CMPA = 1;
    localparam int TMW_FLG_CMPB = 2;
    localparam int TMW_FLG_CAPT = 3;

    // Force strobe bit positions.
    localparam int TMW_FRC_A = 0;
    localparam int TMW_FRC_B = 1;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [15:0] TMW_RST_VALUE = 16'h0000;
    localparam logic [15:0] TMW_MAX = 16'hFFFF;
    localparam logic [15:0] TMW_TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TMW_TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TMW_TOP_10BIT = 16'h03FF;
    localparam logic [31:0] TMW_RDATA_ZERO = 32'h0000_0000;

    // Waveform mode select codes.
    localparam logic [3:0] TMW_MODE_NORMAL = 4'h0;
    localparam logic [3:0] TMW_MODE_CTC_A = 4'h4;
    localparam logic [3:0] TMW_MODE_FAST8 = 4'h5;
    localparam logic [3:0] TMW_MODE_FAST9 = 4'h6;
    localparam logic [3:0] TMW_MODE_FAST10 = 4'h7;
    localparam logic [3:0] TMW_MODE_CTC_C = 4'hC;
    localparam logic [3:0] TMW_MODE_FAST_C = 4'hE;
    localparam logic [3:0] TMW_MODE_FAST_A = 4'hF;

    // Compare output actions.
    typedef enum logic [1:0] {
        TMW_COM_OFF = 2'h0,
        TMW_COM_TOGGLE = 2'h1,
        TMW_COM_CLEAR = 2'h2,
        TMW_COM_SET = 2'h3
    } tmw_com_t;

    // Prescaler select codes and divider count masks.
    localparam logic [2:0] TMW_PRE_STOP = 3'h0;
    localparam logic [2:0] TMW_PRE_1 = 3'h1;
    localparam logic [2:0] TMW_PRE_8 = 3'h2;
    localparam logic [2:0] TMW_PRE_64 = 3'h3;
    localparam logic [2:0] TMW_PRE_256 = 3'h4;
    localparam logic [2:0] TMW_PRE_1024 = 3'h5;
    localparam logic [9:0] TMW_DIV_8 = 10'h007;
    localparam logic [9:0] TMW_DIV_64 = 10'h03F;
    localparam logic [9:0] TMW_DIV_256 = 10'h0FF;
    localparam logic [9:0] TMW_DIV_1024 = 10'h3FF;

    // AHB transfer type.
    localparam logic [1:0] TMW_HTRANS_NONSEQ = 2'h2;

    // Bus request fields that travel together.
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } tmw_ahb_req_t;

    // Compare output state of both channels.
    typedef struct packed {
        logic b;
        logic a;
    } tmw_oc_t;

endpackage : tmw_pkg

// File: verification/tmw_timer_sva.sv
/*
 * Port checker for the timer waveform block.
 * Assumes it is bound onto tmw_timer and sees only its ports.
 */
`timescale 1ns/1ps
module tmw_timer_sva
    import tmw_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [1:0] PORT_OUT,
    input wire logic [1:0] PIN_OUT,
    input wire logic [1:0] PIN_OE
);
    // ------------------------------------------------------------------
    // Bus tracking
    // ------------------------------------------------------------------
    logic wr_q;
    logic [7:0] ad_q;
    logic [12:0] ctl_q;
    wire logic take = HSEL && HREADY && HTRANS == TMW_HTRANS_NONSEQ;
    wire logic rd_take = take && !HWRITE;

    // Keeps a copy of the control word as the slave stores it.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            ctl_q <= 13'h0000;
        end else begin
            wr_q <= take && HWRITE;
            ad_q <= HADDR[7:0];
            if (wr_q && ad_q == TMW_OFS_CTRL) begin
                ctl_q <= HWDATA[12:0];
            end
        end
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("slave stalled or gave an error response");
    reset_clear_a: assert property ($fell(RST) |->
        PIN_OE == 2'h0 && HRDATA == 32'h0000_0000)
        else $error("outputs not cleared by reset");
    dir_follow_a: assert property (wr_q && ad_q == TMW_OFS_CTRL
        |=> PIN_OE == ctl_q[12:11])
        else $error("pin enables do not follow direction bits");
    port_pass_a: assert property (ctl_q[5:4] == 2'h0
        |-> PIN_OUT[0] == PORT_OUT[0])
        else $error("channel A pin not under port control");
    port_pass_b_a: assert property (ctl_q[7:6] == 2'h0
        |-> PIN_OUT[1] == PORT_OUT[1])
        else $error("channel B pin not under port control");
    unmapped_zero_a: assert property (rd_take && HADDR[7:0] >= 8'h20
        |=> HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    high_mask_a: assert property (wr_q && ad_q == TMW_OFS_CMPA
        && ctl_q[3:0] == TMW_MODE_FAST8 ##1
        rd_take && HADDR[7:0] == TMW_OFS_CMPA |=> HRDATA[15:8] == 8'h00)
        else $error("compare bits above 8-bit top kept");
    read_hold_a: assert property (!rd_take |=> $stable(HRDATA))
        else $error("read data changed without a read");
endmodule : tmw_timer_sva

// File: verification/tmw_timer_tb.sv
/*
 * Self-checking bench for the timer waveform block.
 * Assumes a zero-wait AHB-Lite slave and the prescaler at /1 mostly.
 */
`timescale 1ns/1ps
module tmw_timer_tb
    import tmw_pkg::*;
;
    logic clk, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, port_out, pin_out, pin_oe;
    logic [2:0] hsize;
    int error_cnt, total_checks, hi, tg;
    logic [15:0] tops [3] = '{TMW_TOP_8BIT, TMW_TOP_9BIT, TMW_TOP_10BIT};
    logic [3:0] stx [4] = '{4'h1, 4'h0, 4'h1, 4'h1};

    tmw_timer u_dut (.CORE_CLK(clk), .RST(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .PORT_OUT(port_out),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe));

    // Clock of 20 ns period.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // One single transfer: address phase, then data phase.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= TMW_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk

    // Counts high cycles and changes of pin A over n cycles.
    task watch(input int n);
        logic p;
        hi = 0;
        tg = 0;
        p = pin_out[0];
        repeat (n) begin
            @(posedge clk);
            #1;
            hi += int'(pin_out[0] === 1'b1);
            tg += int'(pin_out[0] !== p);
            p = pin_out[0];
        end
        @(posedge clk);
    endtask : watch

    task tally_and_finish;
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Ends a hung run.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        hsel <= 1'b0;
        hwrite <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        port_out <= 2'h2;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) if (i != 6) rchk("reset", 8'(i * 4), 0);
        chk("oe", 32'h0, {30'h0, pin_oe});
        chk("port", 32'h2, {30'h0, pin_out});
        // Normal mode wraps and raises overflow.
        bus(1'b1, TMW_OFS_COUNT, 32'hFFF0);
        bus(1'b1, TMW_OFS_CTRL, 32'h100);
        repeat (30) @(posedge clk);
        bus(1'b1, TMW_OFS_CTRL, 32'h0);
        rchk("ovf", TMW_OFS_FLAGS, 32'h7);
        bus(1'b0, TMW_OFS_COUNT, 32'h0);
        chk("wrap", 32'h10, rd);
        bus(1'b1, TMW_OFS_FLAGS, 32'hF);
        rchk("fclr", TMW_OFS_FLAGS, 0);
        // Divide-by-8 prescaler: one count per eight clocks.
        bus(1'b1, TMW_OFS_COUNT, 32'h0);
        bus(1'b1, TMW_OFS_CTRL, 32'h200);
        repeat (80) @(posedge clk);
        bus(1'b1, TMW_OFS_CTRL, 32'h0);
        bus(1'b0, TMW_OFS_COUNT, 32'h0);
        chk("pre8", 1, 32'(rd >= 32'hA && rd <= 32'hB));
        // Forced actions per output mode, stopped normal mode.
        bus(1'b1, TMW_OFS_COUNT, 32'h1234);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, TMW_OFS_CTRL, 32'((i + 1) % 4) << 4);
            rchk("late", TMW_OFS_STATE, i ? stx[i - 1] : 0);
            bus(1'b1, TMW_OFS_FORCE, 32'h1);
            rchk("force", TMW_OFS_STATE, stx[i]);
        end
        rchk("fflag", TMW_OFS_FLAGS, 0);
        rchk("fcnt", TMW_OFS_COUNT, 32'h1234);
        // Clear-on-match toggling on pin A.
        bus(1'b1, TMW_OFS_CMPA, 32'h3);
        bus(1'b1, TMW_OFS_COUNT, 32'h0);
        bus(1'b1, TMW_OFS_CTRL, 32'h914);
        watch(40);
        chk("tgl", 1, 32'(tg >= 9 && tg <= 11));
        chk("oea", 32'h1, {31'h0, pin_oe[0]});
        bus(1'b0, TMW_OFS_COUNT, 32'h0);
        chk("top", 1, 32'(rd <= 32'h3));
        bus(1'b1, TMW_OFS_CTRL, 32'h4);
        rchk("ctcf", TMW_OFS_FLAGS, 32'h6);
        // Missed match: top below count, then a count write at top.
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, TMW_OFS_CMPA, i ? 32'h20 : 32'h3);
            bus(1'b1, TMW_OFS_COUNT, i ? 32'h20 : 32'hA);
            bus(1'b1, TMW_OFS_CTRL, 32'h104);
            repeat (20) @(posedge clk);
            bus(1'b1, TMW_OFS_CTRL, 32'h4);
            bus(1'b0, TMW_OFS_COUNT, 32'h0);
            chk("miss", 1, 32'(rd > (i ? 32'h20 : 32'hA)));
        end
        // Fixed tops mask compare writes.
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, TMW_OFS_CTRL, 32'(TMW_MODE_FAST8 + i));
            bus(1'b1, TMW_OFS_CMPA, 32'hFFFF);
            rchk("mask", TMW_OFS_CMPA, {16'h0, tops[i]});
        end
        // Fast mode with capture top, both polarities.
        bus(1'b1, TMW_OFS_CTRL, 32'h4);
        bus(1'b1, TMW_OFS_CMPA, 32'h4);
        bus(1'b1, TMW_OFS_CAPT, 32'hF);
        bus(1'b1, TMW_OFS_COUNT, 32'h0);
        for (int i = 2; i < 4; i++) begin
            bus(1'b1, TMW_OFS_FLAGS, 32'hF);
            bus(1'b1, TMW_OFS_CTRL, 32'h90E | (i << 4));
            watch(64);
            if (i == 3) hi = 64 - hi;
            chk("duty", 1, 32'(hi >= 40 && hi <= 50));
            chk("per", 1, 32'(tg >= 7 && tg <= 9));
            bus(1'b1, TMW_OFS_CTRL, 32'hE);
            bus(1'b0, TMW_OFS_FLAGS, 32'h0);
            chk("pwmf", 32'h9, rd & 32'h9);
        end
        tally_and_finish();
    end
endmodule : tmw_timer_tb

bind tmw_timer tmw_timer_sva u_sva (.CORE_CLK(CORE_CLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_OUT(PORT_OUT),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
